/* File: design/icir_pkg.sv */
// constants for the isochronous context interrupt register block
package icir_pkg;
    // ==========================================================
    // bus geometry
    localparam int          ADDR_W         = 12;      // apb byte address width
    localparam int          DATA_W         = 32;      // apb data width
    // ==========================================================
    // register byte offsets
    localparam logic [11:0] OFF_TX_EV_SET  = 12'h090; // tx events, raw / set
    localparam logic [11:0] OFF_TX_EV_CLR  = 12'h094; // tx events, masked / clear
    localparam logic [11:0] OFF_TX_MK_SET  = 12'h098; // tx mask, set
    localparam logic [11:0] OFF_TX_MK_CLR  = 12'h09c; // tx mask, clear
    localparam logic [11:0] OFF_RX_EV_SET  = 12'h0a0; // rx events, raw / set
    localparam logic [11:0] OFF_RX_EV_CLR  = 12'h0a4; // rx events, masked / clear
    localparam logic [11:0] OFF_RX_MK_SET  = 12'h0a8; // rx mask, set
    localparam logic [11:0] OFF_RX_MK_CLR  = 12'h0ac; // rx mask, clear
    localparam logic [11:0] OFF_MAIN_STAT  = 12'h0c0; // aggregate status, read clears
    localparam logic [11:0] OFF_MAIN_MASK  = 12'h0c4; // aggregate mask and enable
    // ==========================================================
    // field positions
    localparam int          TX_AGG_BIT     = 6;       // aggregate transmit dma bit
    localparam int          RX_AGG_BIT     = 7;       // aggregate receive dma bit
    localparam int          GLB_EN_BIT     = 31;      // global interrupt enable bit
    // ==========================================================
    // context counts and reset values
    localparam int          TX_CTX_NUM     = 8;       // transmit contexts
    localparam int          RX_CTX_NUM     = 4;       // receive contexts
    localparam logic        EVENT_RST      = 1'b0;    // event bit after reset
    localparam logic        MASK_RST       = 1'b0;    // mask bit after reset
endpackage

/* File: design/icir_edge_detect.sv */
// rising edge detector for the per-context interrupt levels
`timescale 1ns/100ps
module icir_edge_detect #(
    parameter int WIDTH = 8                  // number of levels watched
) (
    input  wire logic             i_clock,   // register clock
    input  wire logic             i_reset,   // async reset, high
    input  wire logic [WIDTH-1:0] i_level,   // interrupt levels, same clock
    output logic      [WIDTH-1:0] o_rise     // one-cycle pulse per rising edge
);
    // ==========================================================
    // previous level
    logic [WIDTH-1:0] prev_r;                // level seen last cycle

    initial begin
        if (WIDTH < 1 || WIDTH > 31) begin
            $error("icir_edge_detect: WIDTH out of range");
        end
    end

    // held level, so a steady high sets nothing again
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            prev_r <= '0;
        end else begin
            prev_r <= i_level;
        end
    end

    // asserting edge only
    assign o_rise = i_level & ~prev_r;
endmodule

/* File: design/icir_set_clear_reg.sv */
// read/set/clear register bank with hardware set inputs
`timescale 1ns/100ps
module icir_set_clear_reg #(
    parameter int   WIDTH   = 8,             // number of bits
    parameter logic RST_VAL = 1'b0           // value of each bit after reset
) (
    input  wire logic             i_clock,   // register clock
    input  wire logic             i_reset,   // async reset, high
    input  wire logic             i_soft_rst,// sync software reset, high
    input  wire logic [WIDTH-1:0] i_hw_set,  // hardware set pulses
    input  wire logic [WIDTH-1:0] i_wr_set,  // host writes of 1 at set address
    input  wire logic [WIDTH-1:0] i_wr_clr,  // host writes of 1 at clear address
    output logic      [WIDTH-1:0] o_value    // stored bits
);
    // ==========================================================
    // storage
    logic [WIDTH-1:0] val_r;                 // stored bits
    logic [WIDTH-1:0] val_nxt;               // next value

    initial begin
        if (WIDTH < 1 || WIDTH > 31) begin
            $error("icir_set_clear_reg: WIDTH out of range");
        end
    end

    // set wins over clear so no event is lost in a clear cycle
    assign val_nxt = (val_r & ~i_wr_clr) | i_wr_set | i_hw_set;

    // bits change only by set or clear strobes or a reset
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            val_r <= {WIDTH{RST_VAL}};
        end else if (i_soft_rst) begin
            val_r <= {WIDTH{RST_VAL}};
        end else begin
            val_r <= val_nxt;
        end
    end

    assign o_value = val_r;
endmodule

/* File: design/icir_regs.sv */
// isochronous context interrupt event and mask registers behind apb
//
// Behaviour
// RL1 - tx context completion with irq sets event
// RL2 - rx context completion with irq sets event
// RL3 - set on rising edge only, then sticky
// RL4 - write one at set address sets bits
// RL5 - only write one at clear clears
// RL6 - tx event: raw at set, masked at clear
// RL7 - rx event: raw at set, masked at clear
// RL8 - tx bit n is context n; rest zero
// RL9 - rx bit n is context n; rest zero
// RL10 - tx events feed aggregate transmit bit six
// RL11 - rx events feed aggregate receive bit seven
// RL12 - tx mask gates contexts into aggregate
// RL13 - tx mask reads same at both addresses
// RL14 - tx interrupt needs event and mask bit
// RL15 - no interrupt without global enable bit
// RL16 - rx mask set/clear gates rx aggregate
// RL17 - aggregate is any event and mask
// RL18 - reserved bits ignore writes, read zero
`timescale 1ns/100ps
module icir_regs #(
    parameter int TX_CTX = icir_pkg::TX_CTX_NUM,  // transmit contexts
    parameter int RX_CTX = icir_pkg::RX_CTX_NUM   // receive contexts
) (
    input  wire logic                       i_clock,      // 50 mhz register clock
    input  wire logic                       i_reset,      // async reset, high
    input  wire logic                       i_soft_reset, // sync software reset
    input  wire logic [TX_CTX-1:0]          i_tx_ctx_irq, // tx context irq levels
    input  wire logic [RX_CTX-1:0]          i_rx_ctx_irq, // rx context irq levels
    input  wire logic                       i_psel,       // apb select
    input  wire logic                       i_penable,    // apb enable
    input  wire logic                       i_pwrite,     // apb direction
    input  wire logic [icir_pkg::ADDR_W-1:0] i_paddr,     // apb byte address
    input  wire logic [icir_pkg::DATA_W-1:0] i_pwdata,    // apb write data
    input  wire logic [3:0]                 i_pstrb,      // apb byte strobes
    output logic      [icir_pkg::DATA_W-1:0] o_prdata,    // apb read data
    output logic                            o_pready,     // apb ready
    output logic                            o_pslverr,    // apb error
    output logic                            o_tx_dma_aggregate_event, // tx aggregate
    output logic                            o_rx_dma_aggregate_event, // rx aggregate
    output logic                            o_irq         // interrupt, high level
);
    // ==========================================================
    // elaboration checks
    initial begin
        if (TX_CTX < 1 || TX_CTX > 31 || RX_CTX < 1 || RX_CTX > 31) begin
            $error("icir_regs: context count out of range");
        end
    end

    // ==========================================================
    // apb phase decode
    logic        apb_setup;                  // first cycle of a transfer
    logic        apb_access;                 // access cycle, always completes
    logic        apb_wr;                     // write takes effect this edge
    logic        apb_rd;                     // read completes this edge
    logic [31:0] wr_data;                    // write data after strobes

    // byte strobes widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // address compare shared by every register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign apb_setup  = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable;
    assign apb_wr     = apb_access & i_pwrite;
    assign apb_rd     = apb_access & ~i_pwrite;
    assign wr_data    = i_pwdata & strb_mask(i_pstrb);

    // ==========================================================
    // address decode
    logic h_tx_es;                           // tx event set address
    logic h_tx_ec;                           // tx event clear address
    logic h_tx_ms;                           // tx mask set address
    logic h_tx_mc;                           // tx mask clear address
    logic h_rx_es;                           // rx event set address
    logic h_rx_ec;                           // rx event clear address
    logic h_rx_ms;                           // rx mask set address
    logic h_rx_mc;                           // rx mask clear address
    logic h_stat;                            // aggregate status address
    logic h_mmask;                           // aggregate mask address
    logic h_any;                             // any mapped address

    assign h_tx_es = hit(i_paddr, icir_pkg::OFF_TX_EV_SET);
    assign h_tx_ec = hit(i_paddr, icir_pkg::OFF_TX_EV_CLR);
    assign h_tx_ms = hit(i_paddr, icir_pkg::OFF_TX_MK_SET);
    assign h_tx_mc = hit(i_paddr, icir_pkg::OFF_TX_MK_CLR);
    assign h_rx_es = hit(i_paddr, icir_pkg::OFF_RX_EV_SET);
    assign h_rx_ec = hit(i_paddr, icir_pkg::OFF_RX_EV_CLR);
    assign h_rx_ms = hit(i_paddr, icir_pkg::OFF_RX_MK_SET);
    assign h_rx_mc = hit(i_paddr, icir_pkg::OFF_RX_MK_CLR);
    assign h_stat  = hit(i_paddr, icir_pkg::OFF_MAIN_STAT);
    assign h_mmask = hit(i_paddr, icir_pkg::OFF_MAIN_MASK);
    assign h_any   = h_tx_es | h_tx_ec | h_tx_ms | h_tx_mc | h_rx_es | h_rx_ec
                   | h_rx_ms | h_rx_mc | h_stat | h_mmask;

    // ==========================================================
    // write strobes per register
    logic [TX_CTX-1:0] tx_ev_wset;           // tx event set bits
    logic [TX_CTX-1:0] tx_ev_wclr;           // tx event clear bits
    logic [TX_CTX-1:0] tx_mk_wset;           // tx mask set bits
    logic [TX_CTX-1:0] tx_mk_wclr;           // tx mask clear bits
    logic [RX_CTX-1:0] rx_ev_wset;           // rx event set bits
    logic [RX_CTX-1:0] rx_ev_wclr;           // rx event clear bits
    logic [RX_CTX-1:0] rx_mk_wset;           // rx mask set bits
    logic [RX_CTX-1:0] rx_mk_wclr;           // rx mask clear bits

    // RL4 set writes
    // RL18 upper bits dropped
    assign tx_ev_wset = (apb_wr & h_tx_es) ? wr_data[TX_CTX-1:0] : '0;
    assign tx_mk_wset = (apb_wr & h_tx_ms) ? wr_data[TX_CTX-1:0] : '0;
    assign rx_ev_wset = (apb_wr & h_rx_es) ? wr_data[RX_CTX-1:0] : '0;
    assign rx_mk_wset = (apb_wr & h_rx_ms) ? wr_data[RX_CTX-1:0] : '0;
    // RL5 clear writes only
    assign tx_ev_wclr = (apb_wr & h_tx_ec) ? wr_data[TX_CTX-1:0] : '0;
    assign tx_mk_wclr = (apb_wr & h_tx_mc) ? wr_data[TX_CTX-1:0] : '0;
    assign rx_ev_wclr = (apb_wr & h_rx_ec) ? wr_data[RX_CTX-1:0] : '0;
    assign rx_mk_wclr = (apb_wr & h_rx_mc) ? wr_data[RX_CTX-1:0] : '0;

    // ==========================================================
    // context edge detection
    logic [TX_CTX-1:0] tx_rise;              // tx asserting edges
    logic [RX_CTX-1:0] rx_rise;              // rx asserting edges

    // RL1 tx completion edges
    // RL3 edge not level
    icir_edge_detect #(.WIDTH(TX_CTX)) u_tx_edge (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_level (i_tx_ctx_irq),
        .o_rise  (tx_rise)
    );

    // RL2 rx completion edges
    icir_edge_detect #(.WIDTH(RX_CTX)) u_rx_edge (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_level (i_rx_ctx_irq),
        .o_rise  (rx_rise)
    );

    // ==========================================================
    // event and mask banks
    logic [TX_CTX-1:0] tx_event;             // tx per-context events
    logic [TX_CTX-1:0] tx_mask;              // tx per-context enables
    logic [RX_CTX-1:0] rx_event;             // rx per-context events
    logic [RX_CTX-1:0] rx_mask;              // rx per-context enables

    // RL8 tx bit n is context n
    icir_set_clear_reg #(.WIDTH(TX_CTX), .RST_VAL(icir_pkg::EVENT_RST)) u_tx_ev (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_soft_rst (i_soft_reset),
        .i_hw_set   (tx_rise),
        .i_wr_set   (tx_ev_wset),
        .i_wr_clr   (tx_ev_wclr),
        .o_value    (tx_event)
    );

    // RL12 tx mask bank
    icir_set_clear_reg #(.WIDTH(TX_CTX), .RST_VAL(icir_pkg::MASK_RST)) u_tx_mk (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_soft_rst (i_soft_reset),
        .i_hw_set   ({TX_CTX{1'b0}}),
        .i_wr_set   (tx_mk_wset),
        .i_wr_clr   (tx_mk_wclr),
        .o_value    (tx_mask)
    );

    // RL9 rx bit n is context n
    icir_set_clear_reg #(.WIDTH(RX_CTX), .RST_VAL(icir_pkg::EVENT_RST)) u_rx_ev (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_soft_rst (i_soft_reset),
        .i_hw_set   (rx_rise),
        .i_wr_set   (rx_ev_wset),
        .i_wr_clr   (rx_ev_wclr),
        .o_value    (rx_event)
    );

    // RL16 rx mask bank
    icir_set_clear_reg #(.WIDTH(RX_CTX), .RST_VAL(icir_pkg::MASK_RST)) u_rx_mk (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_soft_rst (i_soft_reset),
        .i_hw_set   ({RX_CTX{1'b0}}),
        .i_wr_set   (rx_mk_wset),
        .i_wr_clr   (rx_mk_wclr),
        .o_value    (rx_mask)
    );

    // ==========================================================
    // aggregates
    logic tx_agg;                            // any enabled tx event
    logic rx_agg;                            // any enabled rx event

    // RL10 tx aggregate source
    // RL17 any event and mask
    assign tx_agg = |(tx_event & tx_mask);
    // RL11 rx aggregate source
    assign rx_agg = |(rx_event & rx_mask);

    assign o_tx_dma_aggregate_event = tx_agg;
    assign o_rx_dma_aggregate_event = rx_agg;

    // ==========================================================
    // aggregate status and mask
    logic [1:0] stat_r;                      // sticky {rx, tx} aggregate bits
    logic [1:0] stat_nxt;                    // next status
    logic [1:0] stat_rdclr;                  // read clears status
    logic [1:0] mmask_r;                     // {rx, tx} enables
    logic [1:0] mmask_nxt;                   // next enables
    logic       glb_en_r;                    // global interrupt enable
    logic       glb_en_nxt;                  // next global enable
    logic       mm_wr;                       // write to aggregate mask

    // read of status clears, but a set in the same cycle wins
    assign stat_rdclr = (apb_rd & h_stat) ? 2'b11 : 2'b00;
    assign stat_nxt   = (stat_r & ~stat_rdclr) | {rx_agg, tx_agg};
    assign mm_wr      = apb_wr & h_mmask;
    assign mmask_nxt  = mm_wr ? {wr_data[icir_pkg::RX_AGG_BIT],
                                 wr_data[icir_pkg::TX_AGG_BIT]} : mmask_r;
    assign glb_en_nxt = mm_wr ? wr_data[icir_pkg::GLB_EN_BIT] : glb_en_r;

    // status, mask and enable storage
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            stat_r   <= 2'h0;
            mmask_r  <= 2'h0;
            glb_en_r <= 1'b0;
        end else if (i_soft_reset) begin
            stat_r   <= 2'h0;
            mmask_r  <= 2'h0;
            glb_en_r <= 1'b0;
        end else begin
            stat_r   <= stat_nxt;
            mmask_r  <= mmask_nxt;
            glb_en_r <= glb_en_nxt;
        end
    end

    // RL14 event and mask both
    // RL15 global enable gate
    assign o_irq = glb_en_r & |(stat_r & mmask_r);

    // ==========================================================
    // read data mux
    logic [31:0] rd_value;                   // word for the addressed register
    logic [31:0] stat_word;                  // status in bus layout
    logic [31:0] mmask_word;                 // mask in bus layout
    logic [31:0] prdata_r;                   // registered read data

    assign stat_word  = (32'(stat_r[0]) << icir_pkg::TX_AGG_BIT)
                      | (32'(stat_r[1]) << icir_pkg::RX_AGG_BIT);
    assign mmask_word = (32'(mmask_r[0]) << icir_pkg::TX_AGG_BIT)
                      | (32'(mmask_r[1]) << icir_pkg::RX_AGG_BIT)
                      | (32'(glb_en_r) << icir_pkg::GLB_EN_BIT);

    // RL6 tx raw or masked
    // RL7 rx raw or masked
    // RL13 mask same at both
    // RL18 reserved read zero
    assign rd_value = h_tx_es            ? 32'(tx_event)
                    : h_tx_ec            ? 32'(tx_event & tx_mask)
                    : (h_tx_ms | h_tx_mc) ? 32'(tx_mask)
                    : h_rx_es            ? 32'(rx_event)
                    : h_rx_ec            ? 32'(rx_event & rx_mask)
                    : (h_rx_ms | h_rx_mc) ? 32'(rx_mask)
                    : h_stat             ? stat_word
                    : h_mmask            ? mmask_word
                    : 32'h0000_0000;

    // read data sampled in the setup cycle, held through access
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            prdata_r <= 32'h0000_0000;
        end else if (apb_setup & ~i_pwrite) begin
            prdata_r <= rd_value;
        end
    end

    // zero wait states; unmapped addresses answer with an error
    assign o_prdata  = prdata_r;
    assign o_pready  = 1'b1;
    assign o_pslverr = apb_access & ~h_any;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    AST_TX_EDGE_SET: assert property ( // RL3
        (|tx_rise) && !i_soft_reset |=> ((tx_event & $past(tx_rise)) == $past(tx_rise))
    ) else $error("tx edge did not set event");

    AST_RX_STEADY: assert property ( // RL3
        (rx_event == '0) && $stable(i_rx_ctx_irq) && !(apb_wr & h_rx_es)
        |=> (rx_event == '0)
    ) else $error("rx steady level set an event");

    AST_TX_WSET: assert property ( // RL4
        apb_wr && h_tx_es && !i_soft_reset
        |=> ((tx_event & $past(tx_ev_wset)) == $past(tx_ev_wset))
    ) else $error("tx set write lost");

    AST_TX_CLR_ONLY: assert property ( // RL5
        |($past(tx_event) & ~tx_event) |-> $past(apb_wr & h_tx_ec) || $past(i_soft_reset)
    ) else $error("tx event cleared without clear write");

    AST_TX_MASKED_RD: assert property ( // RL6
        apb_setup && !i_pwrite && h_tx_ec |=> o_prdata == 32'($past(tx_event & tx_mask))
    ) else $error("tx clear read not masked");

    AST_RX_MASKED_RD: assert property ( // RL7
        apb_setup && !i_pwrite && h_rx_ec |=> o_prdata == 32'($past(rx_event & rx_mask))
    ) else $error("rx clear read not masked");

    AST_MASK_SAME: assert property ( // RL13
        apb_setup && !i_pwrite && (h_tx_ms | h_tx_mc) |=> o_prdata == 32'($past(tx_mask))
    ) else $error("tx mask read differs");

    AST_RSVD_ZERO: assert property ( // RL18
        apb_setup && !i_pwrite && !h_mmask |=> o_prdata[31:8] == 24'h000000
    ) else $error("reserved bits read nonzero");

    AST_TX_AGG: assert property ( // RL17
        (|(tx_event & tx_mask)) && !i_soft_reset |=> stat_r[0]
    ) else $error("tx aggregate not recorded");

    AST_GLB_OFF: assert property ( // RL15
        !glb_en_r |-> !o_irq
    ) else $error("interrupt without global enable");

    AST_IRQ_SRC: assert property ( // RL14
        o_irq |-> (stat_r[0] && mmask_r[0]) || (stat_r[1] && mmask_r[1])
    ) else $error("interrupt without enabled source");

    COV_TX_EDGE:  cover property (|tx_rise ##1 (tx_event != '0));
    COV_CLR_READ: cover property (apb_rd && h_tx_ec && (tx_event & tx_mask) != '0);
    COV_IRQ:      cover property (!o_irq ##1 o_irq);
    COV_RX_WSET:  cover property (apb_wr && h_rx_es && rx_ev_wset != '0);
endmodule

/* File: tb/tb_top.sv */
// apb testbench for the isochronous context interrupt registers
`timescale 1ns/100ps
module tb_top;
    // ==========================================================
    // stimulus and observed signals
    logic        i_clock      = 1'b0;   // 50 mhz clock
    logic        i_reset      = 1'b1;   // async reset, high
    logic        i_soft_reset = 1'b0;   // software reset
    logic [7:0]  tx_irq       = 8'h00;  // tx context levels
    logic [3:0]  rx_irq       = 4'h0;   // rx context levels
    logic        psel         = 1'b0;   // apb select
    logic        penable      = 1'b0;   // apb enable
    logic        pwrite       = 1'b0;   // apb direction
    logic [11:0] paddr        = 12'h000; // apb address
    logic [31:0] pwdata       = 32'h0;  // apb write data
    logic [31:0] prdata;                // apb read data
    logic        pready;                // apb ready
    logic        pslverr;               // apb error
    logic        tx_agg;                // tx aggregate
    logic        rx_agg;                // rx aggregate
    logic        irq;                   // interrupt out
    logic [31:0] rd_v;                  // last read word
    logic        err_v;                 // last pslverr
    int          num_errors   = 0;      // mismatches
    int          n_tests      = 0;      // comparisons

    always #10 i_clock = ~i_clock;

    icir_regs dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
        .i_tx_ctx_irq(tx_irq), .i_rx_ctx_irq(rx_irq), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_tx_dma_aggregate_event(tx_agg), .o_rx_dma_aggregate_event(rx_agg), .o_irq(irq));

    // ==========================================================
    // verdict, compares and bus cycles
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // setup then access, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk_bit("pready", 1'b1, 1'b0);
            results();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word($sformatf("word %h", a), exp, rd_v);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge i_clock);
        i_reset <= 1'b0;
        for (int i = 0; i < 8; i++) rdc(12'h090 + 12'(i * 4), 32'h0);
        apb(1'b1, 12'h090, 32'hffffffff);
        rdc(12'h090, 32'h000000ff);
        rdc(12'h090, 32'h000000ff);
        rdc(12'h094, 32'h0);
        apb(1'b1, 12'h094, 32'h0000000f);
        rdc(12'h090, 32'h000000f0);
        apb(1'b1, 12'h094, 32'hffffffff);
        apb(1'b1, 12'h0a0, 32'hffffffff);
        rdc(12'h0a0, 32'h0000000f);
        apb(1'b1, 12'h0a4, 32'h00000005);
        rdc(12'h0a0, 32'h0000000a);
        apb(1'b1, 12'h0a4, 32'hffffffff);
        $display("end of test set and clear");
        // each context level: edge sets one bit, steady level sets nothing again
        for (int k = 0; k < 12; k++) begin
            // one assignment per level per step: next bit rises as the last one falls
            if (k < 8) begin
                tx_irq <= 8'h01 << k;
            end else begin
                tx_irq <= 8'h00;
                rx_irq <= 4'h1 << (k - 8);
            end
            rdc(k < 8 ? 12'h090 : 12'h0a0, 32'h1 << (k % 8));
            apb(1'b1, k < 8 ? 12'h094 : 12'h0a4, 32'h1 << (k % 8));
            rdc(k < 8 ? 12'h090 : 12'h0a0, 32'h0);
        end
        tx_irq <= 8'h00;
        rx_irq <= 4'h0;
        $display("end of test context edges");
        apb(1'b1, 12'h098, 32'hffffff5a);
        rdc(12'h098, 32'h0000005a);
        rdc(12'h09c, 32'h0000005a);
        apb(1'b1, 12'h09c, 32'h0000000a);
        rdc(12'h098, 32'h00000050);
        apb(1'b1, 12'h090, 32'h00000011);
        rdc(12'h094, 32'h00000010);
        chk_bit("pslverr", 1'b0, err_v);
        chk_bit("tx aggregate", 1'b1, tx_agg);
        apb(1'b1, 12'h094, 32'h00000010);
        // the clear lands at the access edge; look one edge later
        @(posedge i_clock);
        chk_bit("tx aggregate", 1'b0, tx_agg);
        apb(1'b1, 12'h0a8, 32'hffffffff);
        rdc(12'h0ac, 32'h0000000f);
        apb(1'b1, 12'h0a0, 32'h00000006);
        rdc(12'h0a4, 32'h00000006);
        chk_bit("rx aggregate", 1'b1, rx_agg);
        apb(1'b1, 12'h0c4, 32'h000000c0);
        repeat (3) @(posedge i_clock);
        chk_bit("irq", 1'b0, irq);
        apb(1'b1, 12'h0c4, 32'h800000c0);
        repeat (3) @(posedge i_clock);
        chk_bit("irq", 1'b1, irq);
        apb(1'b1, 12'h0a4, 32'h0000000f);
        @(posedge i_clock);
        chk_bit("rx aggregate", 1'b0, rx_agg);
        rdc(12'h0c0, 32'h000000c0);
        rdc(12'h0c0, 32'h0);
        chk_bit("irq", 1'b0, irq);
        $display("end of test aggregate and irq");
        rdc(12'h0b0, 32'h0);
        chk_bit("pslverr", 1'b1, err_v);
        @(posedge i_clock);
        i_soft_reset <= 1'b1;
        @(posedge i_clock);
        i_soft_reset <= 1'b0;
        rdc(12'h098, 32'h0);
        rdc(12'h090, 32'h0);
        $display("end of test unmapped and soft reset");
        results();
    end
endmodule
